/* inc/adcscd_pkg.sv */
package adcscd_pkg;
  // ==========================================================
  // command opcodes
  localparam logic [7:0] read_result_cmd         = 8'h01;
  localparam logic [7:0] stream_results_cmd      = 8'h03;
  localparam logic [7:0] halt_stream_cmd         = 8'h0f;
  localparam logic [3:0] register_read_cmd       = 4'h1;
  localparam logic [3:0] register_write_cmd      = 4'h5;
  localparam logic [7:0] internal_full_cal_cmd   = 8'hf0;
  localparam logic [7:0] internal_offset_cal_cmd = 8'hf1;
  localparam logic [7:0] internal_gain_cal_cmd   = 8'hf2;
  localparam logic [7:0] external_offset_cal_cmd = 8'hf3;
  localparam logic [7:0] external_gain_cal_cmd   = 8'hf4;
  localparam logic [7:0] resume_cmd              = 8'hfb;
  localparam logic [7:0] ready_sync_cmd          = 8'hfc;
  localparam logic [7:0] sleep_cmd               = 8'hfd;
  localparam logic [7:0] reset_cmd               = 8'hfe;

  // ==========================================================
  // register map
  localparam int unsigned reg_count     = 16;
  localparam logic [3:0]  id_addr       = 4'h0;
  localparam logic [3:0]  acr_addr      = 4'h2;
  localparam logic [3:0]  ocr_addr      = 4'h7;
  localparam logic [3:0]  fsr_addr      = 4'ha;
  localparam logic [3:0]  result_addr   = 4'hd;
  localparam int unsigned acr_ready_pos = 7;
  localparam int unsigned acr_order_pos = 3;
  localparam logic [7:0]  reg_init [16] = '{
    8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h59, 8'h55, 8'h55, 8'h00, 8'h00, 8'h00};

  // ==========================================================
  // link and buffer
  localparam int unsigned fifo_depth   = 8;
  localparam int unsigned byte_width   = 8;
  localparam logic [1:0]  result_last  = 2'h2;
  localparam logic [2:0]  sync_idle    = 3'h4;

  typedef enum logic [2:0] {
    st_op,
    st_count,
    st_wdata,
    st_rread,
    st_result
  } adcscd_state_t;
endpackage

/* inc/adcscd_fifo_if.sv */
`timescale 1ns/1ps
interface adcscd_fifo_if #(parameter int width = 8);
  logic             push_valid;
  logic             push_ready;
  logic [width-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [width-1:0] pop_data;

  modport user  (output push_valid, push_data, pop_ready,
                 input  push_ready, pop_valid, pop_data);
  modport store (input  push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
endinterface

/* rtl/adcscd_fifo.sv */
`timescale 1ns/1ps
// ==========================================================
// byte buffer; read data leave through an output register
module adcscd_fifo #(
  parameter int width = 8,
  parameter int depth = 8
) (
  input  wire logic    clk,
  input  wire logic    rstn,
  input  wire logic    ce,
  adcscd_fifo_if.store bus
);
  localparam int aw = $clog2(depth);

  logic [width-1:0] mem [depth];
  logic [aw-1:0]    wp;
  logic [aw-1:0]    rp;
  logic [aw:0]      cnt;
  logic             take;
  logic             give;
  logic             load;

  assign take = bus.push_valid && bus.push_ready;
  assign give = bus.pop_valid && bus.pop_ready;
  // refill the output register whenever it is empty or being drained
  assign load = (cnt != '0) && (!bus.pop_valid || give);
  assign bus.push_ready = (cnt != (aw+1)'(depth));

  always_ff @(posedge clk) begin
    if (ce && take) begin
      mem[wp] <= bus.push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp           <= '0;
      rp           <= '0;
      cnt          <= '0;
      bus.pop_valid <= 1'b0;
      bus.pop_data  <= '0;
    end else if (ce) begin
      if (take) begin
        wp <= wp + aw'(1);
      end
      if (load) begin
        bus.pop_data <= mem[rp];
        rp           <= rp + aw'(1);
      end
      if (load) begin
        bus.pop_valid <= 1'b1;
      end else if (give) begin
        bus.pop_valid <= 1'b0;
      end
      cnt <= cnt + (aw+1)'(take) - (aw+1)'(load);
    end
  end
endmodule

/* rtl/adcscd_decoder.sv */
`timescale 1ns/1ps
// ==========================================================
module adcscd_decoder #(
  parameter logic [3:0] chip_id = 4'h0 // arbitrary identity nibble
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  input  wire logic [23:0] result_data,
  input  wire logic        result_strobe,
  output logic             result_ready_n,
  output logic             cal_start,
  output logic [2:0]       cal_kind,
  input  wire logic        cal_done,
  input  wire logic [23:0] cal_offset,
  input  wire logic [23:0] cal_fullscale,
  output logic             sync_pulse,
  output logic             sleep,
  output logic [127:0]     reg_image
);
  adcscd_pkg::adcscd_state_t state;

  logic [2:0]  pin_meta;
  logic [2:0]  pin_sync;
  logic [2:0]  pin_prev;
  logic        sel_n;
  logic        sck_rise;
  logic        sck_fall;
  logic [7:0]  rx_shift;
  logic [2:0]  rx_cnt;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic [7:0]  tx_shift;
  logic [2:0]  tx_cnt;
  logic [7:0]  tx_first;
  logic [7:0]  regs [16];
  logic [3:0]  addr;
  logic [3:0]  remain;
  logic        is_write;
  logic [1:0]  res_idx;
  logic [23:0] res_snap;
  logic        stream;
  logic        op_slot;
  logic        take_op;
  logic        cmd_reset;
  logic        is_cal;
  logic        start_result;
  logic        wr_en;
  logic        push_fire;
  logic        order_lsb;
  logic        upd_offset;
  logic        upd_gain;
  logic [7:0]  next_push;
  logic [7:0]  push_rev;

  adcscd_fifo_if #(.width(adcscd_pkg::byte_width)) fifo_bus ();

  adcscd_fifo #(
    .width (adcscd_pkg::byte_width),
    .depth (adcscd_pkg::fifo_depth)
  ) u_fifo (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .bus  (fifo_bus.store)
  );

  // ==========================================================
  // pin synchronisers, order {cs_n, sclk, din}
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_meta <= adcscd_pkg::sync_idle;
      pin_sync <= adcscd_pkg::sync_idle;
      pin_prev <= adcscd_pkg::sync_idle;
    end else if (ce) begin
      pin_meta <= {cs_n, sclk, din};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign sel_n    = pin_sync[2];
  assign sck_rise = !sel_n && pin_sync[1] && !pin_prev[1];
  assign sck_fall = !sel_n && !pin_sync[1] && pin_prev[1];

  // ==========================================================
  // receive: din taken on falling sclk, msb first
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_shift <= 8'h00;
      rx_cnt   <= 3'h0;
      rx_valid <= 1'b0;
      rx_byte  <= 8'h00;
    end else if (ce) begin
      rx_valid <= 1'b0;
      if (sel_n) begin
        rx_cnt <= 3'h0;
      end else if (sck_fall) begin
        rx_shift <= {rx_shift[6:0], pin_sync[0]};
        rx_cnt   <= rx_cnt + 3'h1;
        if (rx_cnt == 3'h7) begin
          rx_valid <= 1'b1;
          rx_byte  <= {rx_shift[6:0], pin_sync[0]};
        end
      end
    end
  end

  // ==========================================================
  // transmit: dout changes on rising sclk; an empty buffer sends zeros
  assign tx_first          = fifo_bus.pop_valid ? fifo_bus.pop_data : 8'h00;
  assign fifo_bus.pop_ready = sck_rise && (tx_cnt == 3'h0);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_shift <= 8'h00;
      tx_cnt   <= 3'h0;
      dout     <= 1'b0;
    end else if (ce) begin
      if (sel_n) begin
        tx_cnt <= 3'h0;
        dout   <= 1'b0;
      end else if (sck_rise) begin
        tx_cnt <= tx_cnt + 3'h1;
        if (tx_cnt == 3'h0) begin
          dout     <= tx_first[7];
          tx_shift <= {tx_first[6:0], 1'b0};
        end else begin
          dout     <= tx_shift[7];
          tx_shift <= {tx_shift[6:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================
  // opcode decode
  // while streaming only halt and reset are looked at; in sleep only resume
  assign op_slot   = rx_valid && (stream || state == adcscd_pkg::st_op);
  assign take_op   = op_slot && !sleep && !stream;
  assign cmd_reset = op_slot && !sleep && rx_byte == adcscd_pkg::reset_cmd;
  assign is_cal    = rx_byte[7:3] == adcscd_pkg::internal_full_cal_cmd[7:3]
                     && rx_byte[2:0] <= adcscd_pkg::external_gain_cal_cmd[2:0];
  assign start_result = state == adcscd_pkg::st_op && !cmd_reset
                        && ((take_op && rx_byte == adcscd_pkg::read_result_cmd)
                            || (stream && !result_ready_n));
  assign wr_en     = rx_valid && state == adcscd_pkg::st_wdata;
  assign order_lsb = regs[adcscd_pkg::acr_addr][adcscd_pkg::acr_order_pos];

  // ==========================================================
  // command sequencer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state    <= adcscd_pkg::st_op;
      addr     <= 4'h0;
      remain   <= 4'h0;
      is_write <= 1'b0;
      res_idx  <= 2'h0;
      res_snap <= 24'h000000;
    end else if (ce) begin
      unique case (state)
        adcscd_pkg::st_op: begin
          if (start_result) begin
            state    <= adcscd_pkg::st_result;
            res_idx  <= 2'h0;
            res_snap <= {regs[adcscd_pkg::result_addr],
                         regs[adcscd_pkg::result_addr + 4'h1],
                         regs[adcscd_pkg::result_addr + 4'h2]};
          end else if (take_op && (rx_byte[7:4] == adcscd_pkg::register_read_cmd
                       || rx_byte[7:4] == adcscd_pkg::register_write_cmd)) begin
            addr     <= rx_byte[3:0];
            is_write <= rx_byte[7:4] == adcscd_pkg::register_write_cmd;
            state    <= adcscd_pkg::st_count;
          end
        end
        adcscd_pkg::st_count: begin
          if (rx_valid) begin
            remain <= rx_byte[3:0];
            state  <= is_write ? adcscd_pkg::st_wdata : adcscd_pkg::st_rread;
          end
        end
        adcscd_pkg::st_wdata: begin
          if (rx_valid) begin
            addr   <= addr + 4'h1;
            remain <= remain - 4'h1;
            if (remain == 4'h0) begin
              state <= adcscd_pkg::st_op;
            end
          end
        end
        adcscd_pkg::st_rread: begin
          if (push_fire) begin
            addr   <= addr + 4'h1;
            remain <= remain - 4'h1;
            if (remain == 4'h0) begin
              state <= adcscd_pkg::st_op;
            end
          end
        end
        adcscd_pkg::st_result: begin
          if (push_fire) begin
            res_idx  <= res_idx + 2'h1;
            res_snap <= {res_snap[15:0], 8'h00};
            if (res_idx == adcscd_pkg::result_last) begin
              state <= adcscd_pkg::st_op;
            end
          end
        end
      endcase
      if (cmd_reset) begin
        state <= adcscd_pkg::st_op;
      end
    end
  end

  // ==========================================================
  // outgoing bytes; the buffer stalls the sequencer when full
  always_comb begin
    next_push = regs[addr];
    if (addr == adcscd_pkg::acr_addr) begin
      next_push[adcscd_pkg::acr_ready_pos] = result_ready_n;
    end
    if (state == adcscd_pkg::st_result) begin
      next_push = res_snap[23:16];
    end
  end

  assign fifo_bus.push_valid = state == adcscd_pkg::st_result
                               || state == adcscd_pkg::st_rread;
  assign push_rev            = {<<{next_push}};
  assign fifo_bus.push_data  = order_lsb ? push_rev : next_push;
  assign push_fire           = fifo_bus.push_valid && fifo_bus.push_ready;

  // ==========================================================
  // register file
  assign upd_offset = cal_done && (cal_kind == adcscd_pkg::internal_full_cal_cmd[2:0]
                      || cal_kind == adcscd_pkg::internal_offset_cal_cmd[2:0]
                      || cal_kind == adcscd_pkg::external_offset_cal_cmd[2:0]);
  assign upd_gain   = cal_done && (cal_kind == adcscd_pkg::internal_full_cal_cmd[2:0]
                      || cal_kind == adcscd_pkg::internal_gain_cal_cmd[2:0]
                      || cal_kind == adcscd_pkg::external_gain_cal_cmd[2:0]);

  always_ff @(posedge clk) begin
    if (!rstn || (ce && cmd_reset)) begin
      for (int i = 0; i < adcscd_pkg::reg_count; i++) begin
        regs[i] <= adcscd_pkg::reg_init[i];
      end
      regs[adcscd_pkg::id_addr][7:4] <= chip_id;
    end else if (ce) begin
      // identity nibble, ready bit and result bytes ignore writes
      if (wr_en) begin
        if (addr == adcscd_pkg::id_addr) begin
          regs[addr][3:0] <= rx_byte[3:0];
        end else if (addr == adcscd_pkg::acr_addr) begin
          regs[addr][6:0] <= rx_byte[6:0];
        end else if (addr < adcscd_pkg::result_addr) begin
          regs[addr] <= rx_byte;
        end
      end
      if (upd_offset) begin
        regs[adcscd_pkg::ocr_addr]        <= cal_offset[7:0];
        regs[adcscd_pkg::ocr_addr + 4'h1] <= cal_offset[15:8];
        regs[adcscd_pkg::ocr_addr + 4'h2] <= cal_offset[23:16];
      end
      if (upd_gain) begin
        regs[adcscd_pkg::fsr_addr]        <= cal_fullscale[7:0];
        regs[adcscd_pkg::fsr_addr + 4'h1] <= cal_fullscale[15:8];
        regs[adcscd_pkg::fsr_addr + 4'h2] <= cal_fullscale[23:16];
      end
      if (result_strobe) begin
        regs[adcscd_pkg::result_addr]        <= result_data[23:16];
        regs[adcscd_pkg::result_addr + 4'h1] <= result_data[15:8];
        regs[adcscd_pkg::result_addr + 4'h2] <= result_data[7:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < adcscd_pkg::reg_count; gi++) begin : g_img
      assign reg_image[8*gi +: 8] = regs[gi];
    end
  endgenerate

  // ==========================================================
  // modes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stream <= 1'b0;
      sleep  <= 1'b0;
    end else if (ce) begin
      if (take_op && rx_byte == adcscd_pkg::stream_results_cmd) begin
        stream <= 1'b1;
      end else if (stream && op_slot && (rx_byte == adcscd_pkg::halt_stream_cmd
                   || rx_byte == adcscd_pkg::reset_cmd)) begin
        stream <= 1'b0;
      end
      if (take_op && rx_byte == adcscd_pkg::sleep_cmd) begin
        sleep <= 1'b1;
      end else if (sleep && op_slot && rx_byte == adcscd_pkg::resume_cmd) begin
        sleep <= 1'b0;
      end
    end
  end

  // ==========================================================
  // result ready: a new result wins over a read starting in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_ready_n <= 1'b1;
    end else if (ce) begin
      if (result_strobe) begin
        result_ready_n <= 1'b0;
      end else if (start_result || cmd_reset) begin
        result_ready_n <= 1'b1;
      end
    end
  end

  // ==========================================================
  // requests to the converter core; unlisted opcodes fall through
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cal_start  <= 1'b0;
      cal_kind   <= 3'h0;
      sync_pulse <= 1'b0;
    end else if (ce) begin
      cal_start  <= 1'b0;
      sync_pulse <= 1'b0;
      if (take_op && is_cal) begin
        cal_start <= 1'b1;
        cal_kind  <= rx_byte[2:0];
      end
      if (take_op && rx_byte == adcscd_pkg::ready_sync_cmd) begin
        sync_pulse <= 1'b1;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn || !ce);

  sleep_enter_a: assert property (
    take_op && rx_byte == adcscd_pkg::sleep_cmd |=> sleep
  ) else $error("sleep not entered");

  sleep_hold_a: assert property (
    sleep && !(op_slot && rx_byte == adcscd_pkg::resume_cmd) |=> sleep
  ) else $error("sleep left without resume");

  wake_up_a: assert property (
    sleep && op_slot && rx_byte == adcscd_pkg::resume_cmd |=> !sleep
  ) else $error("resume ignored");

  stream_keep_a: assert property (
    stream && !(op_slot && (rx_byte == adcscd_pkg::halt_stream_cmd
    || rx_byte == adcscd_pkg::reset_cmd)) |=> stream
  ) else $error("streaming dropped");

  stream_stop_a: assert property (
    stream && op_slot && rx_byte == adcscd_pkg::halt_stream_cmd |=> !stream
  ) else $error("halt ignored");

  single_read_a: assert property (
    take_op && rx_byte == adcscd_pkg::read_result_cmd && state == adcscd_pkg::st_op
    && !result_strobe
    |=> state == adcscd_pkg::st_result && res_idx == 2'h0 && result_ready_n
  ) else $error("single read not started");

  count_take_a: assert property (
    state == adcscd_pkg::st_count && rx_valid && !cmd_reset
    |=> remain == $past(rx_byte[3:0])
  ) else $error("count nibble wrong");

  addr_wrap_a: assert property (
    state == adcscd_pkg::st_rread && push_fire && addr == 4'hf |=> addr == 4'h0
  ) else $error("address did not wrap");

  write_store_a: assert property (
    wr_en && addr == 4'h5 && !cmd_reset |=> regs[5] == $past(rx_byte)
  ) else $error("write lost");

  reset_cmd_a: assert property (
    cmd_reset |=> regs[5] == 8'hff && !stream && state == adcscd_pkg::st_op
  ) else $error("reset incomplete");

  offset_only_a: assert property (
    cal_done && cal_kind == adcscd_pkg::internal_offset_cal_cmd[2:0] && !cmd_reset
    && !wr_en |=> regs[adcscd_pkg::ocr_addr] == $past(cal_offset[7:0])
    && regs[adcscd_pkg::fsr_addr] == $past(regs[adcscd_pkg::fsr_addr])
  ) else $error("offset calibration update wrong");

  sync_pulse_a: assert property (
    take_op && rx_byte == adcscd_pkg::ready_sync_cmd |=> sync_pulse ##1 !sync_pulse
  ) else $error("sync pulse wrong");

  stream_cover_c: cover property (stream ##[1:1000] state == adcscd_pkg::st_result);
  wrap_cover_c: cover property (state == adcscd_pkg::st_rread && push_fire && addr == 4'hf);
  write_cover_c: cover property (wr_en ##1 state == adcscd_pkg::st_op);
  sleep_cover_c: cover property (sleep ##[1:1000] !sleep);
endmodule

/* tb/adcscd_host.sv */
`timescale 1ns/1ps
// ==========================================================
// host model: link master, mode 1, clock still between frames
module adcscd_host (
  output logic     sclk,
  output logic     cs_n,
  output logic     din,
  input wire logic dout
);
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    din  = 1'h0;
  end
  // din moves late in the low phase, clear of the synchronised fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      #32 din = tx[i];
      #8 sclk = 1'h1;
      #40 rx[i] = dout;
      sclk = 1'h0;
    end
    // a released line must not look like a held bit
    #32 din = ~din;
  endtask
  task automatic sel(input logic on);
    #40 cs_n = ~on;
    #40;
  endtask
endmodule

/* tb/adc_serial_command_decoder_tb.sv */
`timescale 1ns/1ps
module adc_serial_command_decoder_tb;
  logic         clk = 1'h0, rstn = 1'h0, rs = 1'h0, cd = 1'h0, rdy = 1'h1;
  logic         sclk, cs_n, din, dout, rrn, cal_start, sync_pulse, sleep;
  logic [23:0]  rd_data = 24'h0, co = 24'h0, cf = 24'h0, r;
  logic [2:0]   cal_kind;
  logic [127:0] reg_image;
  logic [7:0]   m [16];
  logic [7:0]   rx [$];
  logic [7:0]   d [$];
  logic [7:0]   cnt;
  logic [31:0]  seed = 32'h0001603f;
  int           error_cnt = 0, compares = 0, ncal = 0, nsync = 0, c;

  adcscd_decoder uut (.clk(clk), .rstn(rstn), .ce(1'h1), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .result_data(rd_data), .result_strobe(rs),
    .result_ready_n(rrn), .cal_start(cal_start), .cal_kind(cal_kind), .cal_done(cd),
    .cal_offset(co), .cal_fullscale(cf), .sync_pulse(sync_pulse), .sleep(sleep),
    .reg_image(reg_image));
  adcscd_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (cal_start === 1'h1) ncal++;
    if (sync_pulse === 1'h1) nsync++;
  end

  // ==========================================================
  // expectation model
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] wmask(input logic [3:0] a);
    if (a == 4'h0) return 8'h0f;
    if (a == 4'h2) return 8'h7f;
    return (a > 4'hc) ? 8'h00 : 8'hff;
  endfunction
  // the link shows the live ready level in control bit 7
  function automatic logic [7:0] rd(input logic [3:0] a);
    logic [7:0] v;
    v = (a == 4'h2) ? {rdy, m[2][6:0]} : m[a];
    if (m[2][3]) v = {<<{v}};
    return v;
  endfunction
  function automatic logic [127:0] img();
    for (int i = 0; i < 16; i++) img[8*i +: 8] = m[i];
  endfunction

  // ==========================================================
  // drivers and checks
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rst_model();
    foreach (m[i]) m[i] = adcscd_pkg::reg_init[i];
    rdy = 1'h1;
  endtask
  task automatic strobe(input logic [23:0] v);
    @(posedge clk);
    rd_data <= v;
    rs <= 1'h1;
    @(posedge clk);
    rs <= 1'h0;
    {m[13], m[14], m[15]} = v;
    rdy = 1'h0;
  endtask
  task automatic xact(input logic [7:0] tx [$], input int n, input logic [7:0] fill);
    logic [7:0] b;
    rx = {};
    host.sel(1'h1);
    foreach (tx[i]) host.xfer(tx[i], b);
    if (n > 0) #200;
    repeat (n) begin
      host.xfer(fill, b);
      rx.push_back(b);
    end
    host.sel(1'h0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] n, input logic [7:0] v [$]);
    logic [7:0] q [$];
    logic [3:0] j;
    q = {};
    q.push_back({adcscd_pkg::register_write_cmd, a});
    q.push_back(n);
    foreach (v[k]) begin
      j = a + k[3:0];
      q.push_back(v[k]);
      m[j] = (m[j] & ~wmask(j)) | (v[k] & wmask(j));
    end
    xact(q, 0, 8'h00);
    chk(reg_image, img());
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] n);
    logic [3:0] j;
    xact('{{adcscd_pkg::register_read_cmd, a}, n}, int'(n[3:0]) + 1, 8'h00);
    chk(rx.size(), n[3:0] + 5'h1);
    foreach (rx[k]) begin
      j = a + k[3:0];
      chk(rx[k], rd(j));
    end
  endtask
  task automatic res_chk(input logic [23:0] v);
    logic [7:0] b;
    for (int k = 0; k < 3; k++) begin
      b = v[23 - 8*k -: 8];
      if (m[2][3]) b = {<<{b}};
      chk(rx[k], b);
    end
  endtask

  initial begin
    #400000;
    error_cnt++;
    results();
  end

  initial begin
    rst_model();
    cyc(6);
    rstn <= 1'h1;
    cyc(4);
    chk(reg_image, img());
    for (int t = 0; t < 6; t++) begin
      cnt = 8'(xs()) & 8'hf3;
      d = {};
      repeat (int'(cnt[3:0]) + 1) d.push_back(8'(xs()));
      wr(4'(xs()), cnt, d);
      rdchk(4'(xs()), 8'(xs()));
    end
    wr(4'hf, 8'h02, '{8'ha5, 8'hc3, 8'h3c});
    wr(4'h2, 8'hf0, '{8'h08});
    rdchk(4'hd, 8'h0f);
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      c = ncal;
      xact('{8'hf0 | k[7:0]}, 0, 8'h00);
      chk(ncal - c, 1);
      chk(cal_kind, k[2:0]);
      @(posedge clk);
      co <= 24'(xs());
      cf <= 24'(xs());
      cd <= 1'h1;
      cyc(1);
      cd <= 1'h0;
      if (k inside {0, 1, 3}) {m[9], m[8], m[7]} = co;
      if (k inside {0, 2, 4}) {m[12], m[11], m[10]} = cf;
      cyc(3);
      chk(reg_image, img());
    end
    $display("test calibration done");
    xact('{adcscd_pkg::sleep_cmd}, 0, 8'h00);
    chk(sleep, 1'h1);
    xact('{8'h50, 8'h00, 8'h5a}, 0, 8'h00);
    xact('{adcscd_pkg::ready_sync_cmd}, 0, 8'h00);
    chk({nsync, reg_image}, {32'h0, img()});
    xact('{adcscd_pkg::resume_cmd}, 0, 8'h00);
    chk(sleep, 1'h0);
    xact('{adcscd_pkg::ready_sync_cmd}, 0, 8'h00);
    chk(nsync, 1);
    c = ncal;
    foreach (d[i]) d[i] = 8'h0;
    xact('{8'h02, 8'h04, 8'h20, 8'h77, 8'hff}, 0, 8'h00);
    chk({ncal - c, nsync, sleep, reg_image}, {32'h0, 32'h1, 1'h0, img()});
    $display("test modes done");
    r = 24'(xs());
    strobe(r);
    cyc(3);
    chk(rrn, 1'h0);
    xact('{adcscd_pkg::read_result_cmd}, 3, 8'h00);
    rdy = 1'h1;
    res_chk(r);
    chk(rrn, 1'h1);
    xact('{adcscd_pkg::stream_results_cmd}, 0, 8'h00);
    r = 24'(xs());
    strobe(r);
    cyc(10);
    chk(rrn, 1'h1);
    xact('{}, 3, 8'h00);
    res_chk(r);
    r = 24'(xs());
    strobe(r);
    cyc(10);
    xact('{}, 3, adcscd_pkg::halt_stream_cmd);
    res_chk(r);
    r = 24'(xs());
    strobe(r);
    cyc(20);
    chk(rrn, 1'h0);
    // the pending result is queued as soon as streaming starts
    xact('{adcscd_pkg::stream_results_cmd}, 3, 8'h00);
    res_chk(r);
    xact('{adcscd_pkg::reset_cmd}, 0, 8'h00);
    rst_model();
    chk({rrn, reg_image}, {1'h1, img()});
    strobe(24'(xs()));
    cyc(20);
    chk(rrn, 1'h0);
    rdchk(4'h2, 8'h00);
    $display("test results done");
    results();
  end
endmodule
